// ---- hw/dwlb_pkg.sv ----
// Purpose: shared constants and types for the DDR3 device-side command and leveling block
// Assumes: 25 MHz hclk, CK sampled as a plain input
// Notes: the hclk counts derive from times in ns and the clock period; CK and beat counts are given directly
package dwlb_pkg;
	localparam int CLK_PERIOD_NS = 40;
	localparam int ROW_PRECHARGE_TIME_NS = 14;
	localparam int ROW_PRECHARGE_CYC = (ROW_PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LEVELING_OUTPUT_DELAY_NS = 9;
	localparam int LEVELING_OUTPUT_CYC_RAW = LEVELING_OUTPUT_DELAY_NS / CLK_PERIOD_NS;
	localparam int LEVELING_OUTPUT_CYC = (LEVELING_OUTPUT_CYC_RAW < 1) ? 1 : LEVELING_OUTPUT_CYC_RAW;
	localparam logic [4:0] MODE_REGISTER_UPDATE_DELAY_CK = 5'h0c;
	localparam logic [3:0] COLUMN_TO_COLUMN_SPACING = 4'h4;
	localparam logic [3:0] BEATS_FOUR = 4'h4;
	localparam logic [3:0] BEATS_EIGHT = 4'h8;
	// Register byte offsets
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_LATENCY = 8'h04;
	localparam logic [7:0] OFS_MODE1 = 8'h08;
	localparam logic [7:0] OFS_BURST = 8'h0c;
	localparam logic [7:0] OFS_PATTERN = 8'h10;
	localparam logic [7:0] OFS_ROWSEL = 8'h14;
	// Reset values
	localparam logic [3:0] CAS_LATENCY_RST = 4'h5;
	localparam logic [3:0] ADDITIVE_LATENCY_RST = 4'h0;
	localparam logic [15:0] PATTERN_RST = 16'h0000;
	// Mode register one fields and command address bits
	localparam int LEVELING_ENABLE_BIT = 7;
	localparam int OUTPUT_DISABLE_BIT = 12;
	localparam int BURST_SELECT_ADDRESS_BIT = 12;
	localparam int AUTO_PRECHARGE_BIT = 10;
	localparam logic [2:0] MODE_REG_ONE_BANK = 3'h1;
	// Command codes {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_MODE_SET = 4'h0;
	localparam logic [3:0] CMD_PRECHARGE = 4'h2;
	localparam logic [3:0] CMD_ACTIVATE = 4'h3;
	localparam logic [3:0] CMD_WRITE = 4'h4;
	localparam logic [3:0] CMD_READ = 4'h5;

	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [2:0] bank_select_inputs;
		logic [15:0] addr;
	} dwlb_cmd_t;

	typedef struct packed {
		logic ck;
		logic odt;
		logic upper_lane_strobe;
		logic lower_lane_strobe;
	} dwlb_lvl_t;
endpackage

// ---- hw/dwlb_sync.sv ----
// Purpose: two-flop synchroniser for inputs from outside the hclk domain
// Assumes: each bit is sampled independently
// Notes: only the second stage is visible to other logic
`timescale 1ns/1ps
module dwlb_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_reg;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_reg <= '0;
			q <= '0;
		end else begin
			s1_reg <= d;
			q <= s1_reg;
		end
	end
endmodule

// ---- hw/dwlb_bank.sv ----
// Purpose: row state of one bank: open row and precharge timer
// Assumes: activate and precharge are one-cycle pulses
// Notes: a precharge restarts the timer even when the bank is already closing
`timescale 1ns/1ps
module dwlb_bank
	import dwlb_pkg::*;
#(
	parameter int TW = 4,
	parameter logic [TW-1:0] PRE_CYC = TW'(ROW_PRECHARGE_CYC)
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Commands
	input wire logic act,
	input wire logic pre,
	input wire logic [15:0] row_in,
	// State
	output logic open,
	output logic ready,
	output logic [15:0] row
);
	logic open_next;
	logic [15:0] row_next;
	logic [TW-1:0] tmr_reg;
	logic [TW-1:0] tmr_next;

	always_comb begin
		open_next = open;
		row_next = row;
		tmr_next = tmr_reg;
		if (tmr_reg != '0) begin
			tmr_next = tmr_reg - TW'(1);
		end
		if (pre) begin
			open_next = 1'b0;
			tmr_next = PRE_CYC;
		end else if (act && ready) begin
			open_next = 1'b1;
			row_next = row_in;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			open <= 1'b0;
			row <= '0;
			tmr_reg <= '0;
		end else begin
			open <= open_next;
			row <= row_next;
			tmr_reg <= tmr_next;
		end
	end

	assign ready = (tmr_reg == '0) && !open;
endmodule

// ---- hw/dwlb_top.sv ----
// Purpose: DDR3 device-side write leveling, bank row state and burst selection
// Assumes: CK and all pins are slow against hclk and are synchronised here
// Notes: registers over AHB-Lite, zero wait states, always OKAY
`timescale 1ns/1ps
module dwlb_top
	import dwlb_pkg::*;
#(
	parameter int NBANK = 8
) (
	// AHB-Lite slave
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Command and clock pins
	input wire dwlb_pkg::dwlb_cmd_t cmd_in,
	input wire dwlb_pkg::dwlb_lvl_t lvl_in,
	// Strobe pins, bit 1 is the upper lane
	output logic [1:0] dqs_out,
	output logic [1:0] dqs_oe,
	// Data pins
	output logic [15:0] dq_out,
	output logic [15:0] dq_oe,
	// Termination state
	output logic strobe_term_on,
	output logic dq_term_on
);
	typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_BURST} dwlb_rd_t;

	dwlb_cmd_t cmd_s;
	dwlb_lvl_t lvl_s;
	logic ck_d_reg;
	logic [1:0] dqs_d_reg;
	logic ck_rise;
	logic ck_fall;
	logic [1:0] dqs_rise;

	dwlb_sync #(.W($bits(dwlb_cmd_t))) u_sync_cmd (
		.hclk(hclk),
		.hresetn(hresetn),
		.d(cmd_in),
		.q(cmd_s)
	);

	dwlb_sync #(.W($bits(dwlb_lvl_t))) u_sync_lvl (
		.hclk(hclk),
		.hresetn(hresetn),
		.d(lvl_in),
		.q(lvl_s)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ck_d_reg <= 1'b0;
			dqs_d_reg <= 2'h0;
		end else begin
			ck_d_reg <= lvl_s.ck;
			dqs_d_reg <= {lvl_s.upper_lane_strobe, lvl_s.lower_lane_strobe};
		end
	end

	assign ck_rise = lvl_s.ck && !ck_d_reg;
	assign ck_fall = !lvl_s.ck && ck_d_reg;
	assign dqs_rise = {lvl_s.upper_lane_strobe, lvl_s.lower_lane_strobe} & ~dqs_d_reg;

	// Command decode on CK rising edge
	logic [3:0] code;
	logic is_mrs;
	logic is_pre;
	logic is_act;
	logic is_rd;
	logic is_wr;

	assign code = {cmd_s.cs_n, cmd_s.ras_n, cmd_s.cas_n, cmd_s.we_n};
	assign is_mrs = ck_rise && (code == CMD_MODE_SET);
	assign is_pre = ck_rise && (code == CMD_PRECHARGE);
	assign is_act = ck_rise && (code == CMD_ACTIVATE);
	assign is_rd = ck_rise && (code == CMD_READ);
	assign is_wr = ck_rise && (code == CMD_WRITE);

	// Banks
	logic [NBANK-1:0] bank_open;
	logic [NBANK-1:0] bank_ready;
	logic [15:0] bank_row [NBANK];

	for (genvar b = 0; b < NBANK; b++) begin : g_bank
		logic hit;
		assign hit = cmd_s.bank_select_inputs == 3'(b);
		dwlb_bank u_bank (
			.hclk(hclk),
			.hresetn(hresetn),
			.act(is_act && hit),
			.pre(is_pre && (hit || cmd_s.addr[AUTO_PRECHARGE_BIT])),
			.row_in(cmd_s.addr),
			.open(bank_open[b]),
			.ready(bank_ready[b]),
			.row(bank_row[b])
		);
	end

	// Device state
	logic [15:0] mode1_reg, mode1_next;
	logic lvl_reg, lvl_next;
	logic [4:0] exit_cnt_reg, exit_cnt_next;
	logic [1:0] fb_val_reg, fb_val_next;
	logic [1:0] fb_pend_reg, fb_pend_next;
	logic [3:0] fb_cnt_reg [2];
	logic [3:0] fb_cnt_next [2];
	logic eight_reg, eight_next;
	logic wr_flag_reg, wr_flag_next;
	logic [2:0] bnk_reg, bnk_next;
	logic [10:0] col_reg, col_next;
	dwlb_rd_t rd_reg, rd_next;
	logic [4:0] lat_cnt_reg, lat_cnt_next;
	logic [3:0] beat_reg, beat_next;
	logic [3:0] len_reg, len_next;
	logic [1:0] dqs_out_next, dqs_oe_next;
	logic [15:0] dq_out_next, dq_oe_next;
	logic strobe_term_next, dq_term_next;
	logic [3:0] cas_lat_reg;
	logic [3:0] add_lat_reg;
	logic [15:0] pattern_reg;
	logic [4:0] read_latency;

	assign read_latency = 5'(cas_lat_reg) + 5'(add_lat_reg);

	always_comb begin
		mode1_next = mode1_reg;
		lvl_next = lvl_reg;
		exit_cnt_next = exit_cnt_reg;
		fb_val_next = fb_val_reg;
		fb_pend_next = fb_pend_reg;
		fb_cnt_next = fb_cnt_reg;
		eight_next = eight_reg;
		wr_flag_next = wr_flag_reg;
		bnk_next = bnk_reg;
		col_next = col_reg;
		rd_next = rd_reg;
		lat_cnt_next = lat_cnt_reg;
		beat_next = beat_reg;
		len_next = len_reg;
		dqs_out_next = dqs_out;
		dqs_oe_next = dqs_oe;
		dq_out_next = dq_out;
		dq_oe_next = 16'h0000;
		// Mode register one write
		if (is_mrs && cmd_s.bank_select_inputs == MODE_REG_ONE_BANK) begin
			mode1_next = cmd_s.addr;
			lvl_next = cmd_s.addr[LEVELING_ENABLE_BIT];
			if (lvl_reg && !cmd_s.addr[LEVELING_ENABLE_BIT]) begin
				exit_cnt_next = MODE_REGISTER_UPDATE_DELAY_CK;
			end
			if (!lvl_reg && cmd_s.addr[LEVELING_ENABLE_BIT]) begin
				fb_pend_next = 2'h0;
				fb_val_next = 2'h0;
				dq_out_next = 16'h0000;
			end
		end else if (exit_cnt_reg != 5'h00 && ck_rise) begin
			exit_cnt_next = exit_cnt_reg - 5'h01;
		end
		// Leveling feedback per byte lane
		for (int l = 0; l < 2; l++) begin
			if (fb_pend_reg[l]) begin
				if (fb_cnt_reg[l] == 4'h0) begin
					fb_pend_next[l] = 1'b0;
					dq_out_next[l*8 +: 8] = {8{fb_val_reg[l]}};
				end else begin
					fb_cnt_next[l] = fb_cnt_reg[l] - 4'h1;
				end
			end
			if (lvl_reg && dqs_rise[l]) begin
				fb_val_next[l] = lvl_s.ck;
				fb_pend_next[l] = 1'b1;
				fb_cnt_next[l] = 4'(LEVELING_OUTPUT_CYC - 1);
			end
		end
		if (lvl_reg || exit_cnt_reg != 5'h00) begin
			dq_oe_next = 16'hffff;
		end
		// Column access and read engine
		if ((is_rd || is_wr) && !lvl_reg) begin
			eight_next = cmd_s.addr[BURST_SELECT_ADDRESS_BIT];
			len_next = cmd_s.addr[BURST_SELECT_ADDRESS_BIT] ? BEATS_EIGHT : BEATS_FOUR;
			col_next = {cmd_s.addr[11], cmd_s.addr[9:0]};
			bnk_next = cmd_s.bank_select_inputs;
			wr_flag_next = is_wr;
		end
		case (rd_reg)
			RD_IDLE: begin
				dqs_oe_next = 2'h0;
				if (is_rd && !lvl_reg) begin
					rd_next = RD_WAIT;
					lat_cnt_next = 5'h00;
				end
			end
			RD_WAIT: begin
				if (ck_rise) begin
					lat_cnt_next = lat_cnt_reg + 5'h01;
					if (lat_cnt_reg + 5'h02 == read_latency) begin
						dqs_oe_next = 2'h3;
						dqs_out_next = 2'h0;
					end
					if (lat_cnt_reg + 5'h01 == read_latency) begin
						rd_next = RD_BURST;
						dq_oe_next = 16'hffff;
						dqs_oe_next = 2'h3;
						dqs_out_next = 2'h3;
						dq_out_next = pattern_reg;
						beat_next = 4'h1;
					end
				end
			end
			RD_BURST: begin
				dq_oe_next = 16'hffff;
				if (ck_rise || ck_fall) begin
					if (beat_reg == len_reg) begin
						rd_next = RD_IDLE;
						dqs_oe_next = 2'h0;
						dqs_out_next = 2'h0;
						dq_oe_next = 16'h0000;
					end else begin
						dqs_out_next = {2{~beat_reg[0]}};
						dq_out_next = pattern_reg + 16'(beat_reg);
						beat_next = beat_reg + 4'h1;
					end
				end
			end
			default: rd_next = RD_IDLE;
		endcase
		// Termination: strobes only while leveling
		if (lvl_reg) begin
			strobe_term_next = lvl_s.odt;
			dq_term_next = 1'b0;
		end else begin
			strobe_term_next = lvl_s.odt;
			dq_term_next = lvl_s.odt;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode1_reg <= 16'h0000;
			lvl_reg <= 1'b0;
			exit_cnt_reg <= 5'h00;
			fb_val_reg <= 2'h0;
			fb_pend_reg <= 2'h0;
			fb_cnt_reg <= '{default: 4'h0};
			eight_reg <= 1'b0;
			wr_flag_reg <= 1'b0;
			bnk_reg <= 3'h0;
			col_reg <= 11'h000;
			rd_reg <= RD_IDLE;
			lat_cnt_reg <= 5'h00;
			beat_reg <= 4'h0;
			len_reg <= BEATS_EIGHT;
			dqs_out <= 2'h0;
			dqs_oe <= 2'h0;
			dq_out <= 16'h0000;
			dq_oe <= 16'h0000;
			strobe_term_on <= 1'b0;
			dq_term_on <= 1'b0;
		end else begin
			mode1_reg <= mode1_next;
			lvl_reg <= lvl_next;
			exit_cnt_reg <= exit_cnt_next;
			fb_val_reg <= fb_val_next;
			fb_pend_reg <= fb_pend_next;
			fb_cnt_reg <= fb_cnt_next;
			eight_reg <= eight_next;
			wr_flag_reg <= wr_flag_next;
			bnk_reg <= bnk_next;
			col_reg <= col_next;
			rd_reg <= rd_next;
			lat_cnt_reg <= lat_cnt_next;
			beat_reg <= beat_next;
			len_reg <= len_next;
			dqs_out <= dqs_out_next;
			dqs_oe <= dqs_oe_next;
			dq_out <= dq_out_next;
			dq_oe <= dq_oe_next;
			strobe_term_on <= strobe_term_next;
			dq_term_on <= dq_term_next;
		end
	end

	// AHB-Lite register slave
	logic wr_pend_reg, wr_pend_next;
	logic [7:0] wr_addr_reg, wr_addr_next;
	logic [31:0] hrdata_next;
	logic [3:0] cas_lat_next;
	logic [3:0] add_lat_next;
	logic [15:0] pattern_next;
	logic [2:0] rowsel_reg, rowsel_next;
	logic take;
	logic [7:0] ofs;

	assign take = hsel && htrans[1] && hready;
	assign ofs = haddr[7:0];

	always_comb begin
		wr_pend_next = take && hwrite;
		wr_addr_next = take ? ofs : wr_addr_reg;
		hrdata_next = 32'h0000_0000;
		cas_lat_next = cas_lat_reg;
		add_lat_next = add_lat_reg;
		pattern_next = pattern_reg;
		rowsel_next = rowsel_reg;
		if (wr_pend_reg) begin
			if (wr_addr_reg == OFS_LATENCY) begin
				cas_lat_next = hwdata[3:0];
				add_lat_next = hwdata[7:4];
			end else if (wr_addr_reg == OFS_PATTERN) begin
				pattern_next = hwdata[15:0];
			end else if (wr_addr_reg == OFS_ROWSEL) begin
				rowsel_next = hwdata[18:16];
			end
		end
		if (take && !hwrite) begin
			if (ofs == OFS_STATUS) begin
				hrdata_next = {8'h00, bank_ready, bank_open, 3'h0,
					exit_cnt_reg != 5'h00, rd_reg != RD_IDLE, dq_term_on, strobe_term_on, lvl_reg};
			end else if (ofs == OFS_LATENCY) begin
				hrdata_next = {24'h000000, add_lat_reg, cas_lat_reg};
			end else if (ofs == OFS_MODE1) begin
				hrdata_next = {16'h0000, mode1_reg};
			end else if (ofs == OFS_BURST) begin
				hrdata_next = {5'h00, col_reg, 11'h000, bnk_reg, wr_flag_reg, eight_reg};
			end else if (ofs == OFS_PATTERN) begin
				hrdata_next = {16'h0000, pattern_reg};
			end else if (ofs == OFS_ROWSEL) begin
				hrdata_next = {13'h0000, rowsel_reg, bank_row[rowsel_reg]};
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			cas_lat_reg <= CAS_LATENCY_RST;
			add_lat_reg <= ADDITIVE_LATENCY_RST;
			pattern_reg <= PATTERN_RST;
			rowsel_reg <= 3'h0;
		end else begin
			wr_pend_reg <= wr_pend_next;
			wr_addr_reg <= wr_addr_next;
			hrdata <= hrdata_next;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			cas_lat_reg <= cas_lat_next;
			add_lat_reg <= add_lat_next;
			pattern_reg <= pattern_next;
			rowsel_reg <= rowsel_next;
		end
	end
endmodule

// ---- tb/dwlb_checker.sv ----
// Purpose: assertions on termination and leveling feedback pins
// Assumes: pins are synchronised inside the block, a few hclk of lag
// Notes: leveling is seen as all data enabled with no read strobe
`timescale 1ns/1ps
module dwlb_checker
	import dwlb_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus response
	input wire logic hreadyout,
	input wire logic hresp,
	// Pins
	input wire dwlb_pkg::dwlb_lvl_t lvl_in,
	input wire logic [1:0] dqs_oe,
	input wire logic [15:0] dq_out,
	input wire logic [15:0] dq_oe,
	input wire logic strobe_term_on,
	input wire logic dq_term_on
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic lvl;
	assign lvl = (dq_oe == 16'hffff) && (dqs_oe == 2'b00);
	term_on_a: assert property (lvl_in.odt [*5] |-> strobe_term_on)
		else $error("strobe termination stays off");
	term_off_a: assert property ((!lvl_in.odt) [*5] |-> !strobe_term_on && !dq_term_on)
		else $error("termination stays on");
	dq_term_lvl_a: assert property (lvl |-> !dq_term_on)
		else $error("data termination on while leveling");
	lane_low_a: assert property ($rose(lvl_in.lower_lane_strobe) && lvl_in.ck && lvl
		|-> ##[2:7] dq_out[7:0] == 8'hff) else $error("lower lane missed clock high");
	lane_up_a: assert property ($rose(lvl_in.upper_lane_strobe) && !lvl_in.ck && lvl
		|-> ##[2:7] dq_out[15:8] == 8'h00) else $error("upper lane missed clock low");
	no_rdstrobe_a: assert property ($rose(lvl_in.lower_lane_strobe) && lvl
		|-> (dqs_oe == 2'b00) [*6]) else $error("strobe driven while leveling");
	lane_uniform_a: assert property (lvl |-> dq_out[7:0] inside {8'h00, 8'hff})
		else $error("lower lane bits differ");
	oe_whole_a: assert property (dq_oe inside {16'h0000, 16'hffff})
		else $error("data enables split");
	bus_ok_a: assert property (hreadyout && !hresp)
		else $error("bus wait or error");
endmodule

bind dwlb_top dwlb_checker i_dwlb_checker (.hclk(hclk), .hresetn(hresetn),
	.hreadyout(hreadyout), .hresp(hresp), .lvl_in(lvl_in), .dqs_oe(dqs_oe),
	.dq_out(dq_out), .dq_oe(dq_oe), .strobe_term_on(strobe_term_on), .dq_term_on(dq_term_on));

// ---- tb/dwlb_ctl_model.sv ----
// Purpose: memory controller model driving commands, clock and strobes
// Assumes: free running clock of 320 ns, one command per clock
// Notes: idle address lines show the inverse of the last command
`timescale 1ns/1ps
module dwlb_ctl_model
	import dwlb_pkg::*;
(
	// Pins towards the device
	output var dwlb_pkg::dwlb_cmd_t cmd,
	output var dwlb_pkg::dwlb_lvl_t lvl
);
	initial begin
		cmd = {4'hf, 3'h0, 16'h0};
		lvl = '0;
		#17;
		forever #160 lvl.ck = ~lvl.ck;
	end
	task automatic issue(input logic [3:0] c, input logic [2:0] ba, input logic [15:0] a);
		@(negedge lvl.ck);
		cmd <= {c, ba, a};
		@(negedge lvl.ck);
		cmd <= {4'h7, ~ba, ~a};
	endtask
	task automatic ck_wait(input int n);
		repeat (n) @(posedge lvl.ck);
	endtask
	task automatic set_odt(input logic v);
		@(negedge lvl.ck);
		lvl.odt <= v;
	endtask
	// One rising strobe edge, placed in the high or low half of the clock
	task automatic probe(input logic up, input logic hi);
		if (hi) @(posedge lvl.ck); else @(negedge lvl.ck);
		#80;
		if (up) lvl.upper_lane_strobe = 1'b1; else lvl.lower_lane_strobe = 1'b1;
		#120;
		lvl.upper_lane_strobe = 1'b0;
		lvl.lower_lane_strobe = 1'b0;
	endtask
	task automatic lvl_enter;
		// Single rank: outputs stay enabled, nominal termination left off
		issue(CMD_MODE_SET, MODE_REG_ONE_BANK, 16'h0080);
		ck_wait(12);
		set_odt(1'b1);
		ck_wait(2);
	endtask
	task automatic lvl_exit;
		set_odt(1'b0);
		ck_wait(2);
		issue(CMD_MODE_SET, MODE_REG_ONE_BANK, 16'h0000);
		ck_wait(13);
	endtask
endmodule

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for leveling, bank state and bursts
// Assumes: bus hready is the block's hreadyout
// Notes: expected values queue up, a monitor compares in order
`timescale 1ns/1ps
module testbench;
	import dwlb_pkg::*;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, strobe_term_on, dq_term_on;
	logic [31:0] haddr, hwdata, hrdata, got;
	logic [1:0] htrans, dqs_out, dqs_oe;
	logic [2:0] hsize;
	logic [15:0] dq_out, dq_oe, pat, row;
	dwlb_cmd_t cmd_in;
	dwlb_lvl_t lvl_in;
	logic [31:0] q[$];
	int n_fail = 0;
	int check_count = 0;
	integer seed = 32'h61c2fdc6;
	event got_ev;
	assign hready = hreadyout;
	dwlb_top i_dwlb_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cmd_in(cmd_in),
		.lvl_in(lvl_in), .dqs_out(dqs_out), .dqs_oe(dqs_oe), .dq_out(dq_out), .dq_oe(dq_oe),
		.strobe_term_on(strobe_term_on), .dq_term_on(dq_term_on));
	dwlb_ctl_model i_dwlb_ctl_model (.cmd(cmd_in), .lvl(lvl_in));
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end
	task automatic post(input logic [31:0] g);
		got = g;
		->got_ev;
		#1;
	endtask
	task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= w ? d : $random(seed);
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task automatic rd(input logic [31:0] a, e);
		logic [31:0] r;
		q.push_back(e);
		ahb(1'b0, a, 32'h0, r);
		post(r);
	endtask
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask
	task automatic pin(input logic [31:0] g, e);
		q.push_back(e);
		post(g);
	endtask
	task automatic finish_test;
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial forever begin
		@(got_ev);
		check_count++;
		if (got !== q[0]) begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, q[0]);
		end
		void'(q.pop_front());
	end
	// The sequence needs under a thousand hclk cycles; this is ample margin
	initial begin
		#(40 * 20000);
		n_fail++;
		finish_test;
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		pat = 16'($random(seed));
		row = 16'($random(seed));
		rd(32'h04, 32'h00000005);
		rd(32'h10, 32'h0);
		wr(32'h10, {16'h0, pat});
		wr(32'h40, 32'hffffffff);
		rd(32'h40, 32'h0);
		rd(32'h10, {16'h0, pat});
		$display("test registers done");
		i_dwlb_ctl_model.lvl_enter();
		rd(32'h00, 32'h00ff0003);
		pin({30'h0, strobe_term_on, dq_term_on}, 32'h2);
		i_dwlb_ctl_model.probe(1'b0, 1'b1);
		i_dwlb_ctl_model.probe(1'b1, 1'b0);
		i_dwlb_ctl_model.ck_wait(2);
		pin({16'h0, dq_out}, 32'h00ff);
		i_dwlb_ctl_model.probe(1'b0, 1'b0);
		i_dwlb_ctl_model.probe(1'b1, 1'b1);
		i_dwlb_ctl_model.ck_wait(2);
		pin({16'h0, dq_out}, 32'hff00);
		i_dwlb_ctl_model.lvl_exit();
		rd(32'h00, 32'h00ff0000);
		$display("test leveling done");
		i_dwlb_ctl_model.issue(CMD_ACTIVATE, 3'h2, row);
		i_dwlb_ctl_model.ck_wait(2);
		wr(32'h14, 32'h00020000);
		rd(32'h14, {16'h0002, row});
		rd(32'h00, 32'h00fb0400);
		i_dwlb_ctl_model.issue(CMD_ACTIVATE, 3'h2, ~row);
		i_dwlb_ctl_model.ck_wait(2);
		rd(32'h14, {16'h0002, row});
		i_dwlb_ctl_model.issue(CMD_READ, 3'h2, 16'h1805);
		repeat (400) begin
			@(posedge hclk);
			if (dqs_oe[0] === 1'b1 && dqs_out[0] === 1'b1)
				break;
		end
		pin({dq_oe, dq_out}, {16'hffff, pat});
		repeat (40) begin
			@(posedge hclk);
			if (dqs_out[0] === 1'b0)
				break;
		end
		pin({16'h0, dq_out}, {16'h0, pat + 16'h0001});
		i_dwlb_ctl_model.ck_wait(12);
		pin({14'h0, dqs_oe, dq_oe}, 32'h0);
		rd(32'h0c, 32'h04050009);
		i_dwlb_ctl_model.issue(CMD_WRITE, 3'h2, 16'h0003);
		i_dwlb_ctl_model.ck_wait(2);
		rd(32'h0c, 32'h0003000a);
		i_dwlb_ctl_model.issue(CMD_PRECHARGE, 3'h2, 16'h0000);
		i_dwlb_ctl_model.ck_wait(2);
		rd(32'h00, 32'h00ff0000);
		i_dwlb_ctl_model.issue(CMD_PRECHARGE, 3'h2, 16'h0000);
		i_dwlb_ctl_model.ck_wait(2);
		rd(32'h00, 32'h00ff0000);
		i_dwlb_ctl_model.issue(CMD_ACTIVATE, 3'h5, row);
		i_dwlb_ctl_model.ck_wait(2);
		rd(32'h00, 32'h00df2000);
		i_dwlb_ctl_model.issue(CMD_PRECHARGE, 3'h0, 16'h0400);
		i_dwlb_ctl_model.ck_wait(2);
		rd(32'h00, 32'h00ff0000);
		$display("test banks done");
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rd(32'h00, 32'h00ff0000);
		rd(32'h10, 32'h0);
		rd(32'h04, 32'h00000005);
		pin({14'h0, dqs_oe, dq_oe}, 32'h0);
		$display("test reset done");
		@(posedge hclk);
		finish_test;
	end
endmodule
